// ==== fan_monitor_status_config.v ====
// Status and fan configuration register bank of a temperature monitor with two fans.
// Assumes monitor events come from logic on aclk; only the thermal pin is asynchronous.
// How it works
// RULE1: Alarm-speed flag stays quiet after read while persisting
// RULE2: Fan-two stall or underspeed sets fault flag
// RULE3: Remote-two limit flags reassert each monitoring cycle
// RULE4: Remote-two thermal flag clears on status read
// RULE5: Diode error caught once, survives status reads
// RULE6: Local thermal flag clears on status read
// RULE7: Thermal pin low sets flag, read clears
// RULE8: Fraction bits: remote one, remote two, local
// RULE9: Spin-up code selects 200 ms to 8 s
// RULE10: Frequency code selects PWM rate, default 31.25 Hz
// RULE11: Speed nibbles: normal or minimum, reset 0x05; the code resets the register to 0x55
// RULE12: Spin-up disable bit skips the boost
// RULE13: Ramp code picks factor 1, 2, 4, 8
// RULE14: Sample-rate code doubles rate from 87.5 Hz
// RULE15: Two independent fan filter enables
// RULE16: Control source bit: one automatic, reset automatic
// RULE17: Filter register at 0x23, reset 0x50
// RULE18: Full duty during spin-up from rest
`include "fan_monitor_status_config_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fan_monitor_status_config #(
  parameter [31:0] MS_CYCLES = 32'd50000, // Cycles per millisecond tick
  parameter [31:0] ADC_BASE_CYCLES = 32'd571428, // Cycles per 87.5 Hz sample
  parameter [31:0] PWM_DIV = 32'd1 // Divides PWM periods in simulation
) (
  input wire aclk, // System clock, 50 MHz
  input wire aresetn, // Synchronous reset, active low
  input wire [11:0] awaddr, // Write address
  input wire [2:0] awprot, // Write protection, unused
  input wire awvalid, // Write address valid
  output reg awready, // Write address ready
  input wire [31:0] wdata, // Write data
  input wire [3:0] wstrb, // Write byte enables
  input wire wvalid, // Write data valid
  output reg wready, // Write data ready
  output reg [1:0] bresp, // Write response
  output reg bvalid, // Write response valid
  input wire bready, // Write response ready
  input wire [11:0] araddr, // Read address
  input wire [2:0] arprot, // Read protection, unused
  input wire arvalid, // Read address valid
  output reg arready, // Read address ready
  output reg [31:0] rdata, // Read data
  output reg [1:0] rresp, // Read response
  output reg rvalid, // Read data valid
  input wire rready, // Read data ready
  input wire monitor_cycle, // One-cycle pulse at end of each monitoring cycle
  input wire fan_two_alarm_speed, // Fan two runs at alarm speed
  input wire fan_two_stalled, // Fan two stuck or under speed
  input wire remote_two_above_high, // Remote two above its high limit
  input wire remote_two_below_low, // Remote two below its low limit
  input wire remote_two_over_therm, // Remote two past its thermal limit
  input wire remote_two_diode_fault, // Remote two diode short or open
  input wire local_over_therm, // Local channel past its thermal limit
  input wire therm_pin_n, // Thermal pin level, asynchronous, active low
  input wire [2:0] frac_remote_one, // Fraction bits of remote one
  input wire [2:0] frac_remote_two, // Fraction bits of remote two
  input wire [1:0] frac_local, // Fraction bits of local channel
  input wire [3:0] auto_demand_one, // Loop demand for fan one
  input wire [3:0] auto_demand_two, // Loop demand for fan two
  output reg control_source_select, // High for automatic control
  output reg [3:0] fan_duty_one, // Applied duty nibble, fan one
  output reg [3:0] fan_duty_two, // Applied duty nibble, fan two
  output reg pwm_fan_one, // PWM drive, fan one
  output reg pwm_fan_two, // PWM drive, fan two
  output reg fan_filter_en_one, // Speed filter enable, fan one
  output reg fan_filter_en_two, // Speed filter enable, fan two
  output reg [3:0] ramp_factor, // Ramp rate factor 1, 2, 4 or 8
  output reg adc_sample_tick // One-cycle pulse per converter sample
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Spin-up time in ms per code
  function [12:0] spin_ms;
    input [2:0] code;
    begin
      case (code)
        3'h0: spin_ms = `SPIN_MS_0;
        3'h1: spin_ms = `SPIN_MS_1;
        3'h2: spin_ms = `SPIN_MS_2;
        3'h3: spin_ms = `SPIN_MS_3;
        3'h4: spin_ms = `SPIN_MS_4;
        3'h5: spin_ms = `SPIN_MS_5;
        3'h6: spin_ms = `SPIN_MS_6;
        default: spin_ms = `SPIN_MS_7;
      endcase
    end
  endfunction

  // PWM period in cycles per frequency code, 64-bit to avoid overflow
  function [31:0] pwm_period;
    input [2:0] code;
    reg [63:0] mhz;
    reg [63:0] cyc;
    begin
      case (code)
        3'h0: mhz = `PWM_MHZ_0;
        3'h1: mhz = `PWM_MHZ_1;
        3'h2: mhz = `PWM_MHZ_2;
        3'h3: mhz = `PWM_MHZ_3;
        3'h4: mhz = `PWM_MHZ_4;
        3'h5: mhz = `PWM_MHZ_5;
        3'h6: mhz = `PWM_MHZ_6;
        default: mhz = `PWM_MHZ_7;
      endcase
      cyc = ((`CLK_HZ * `MS_PER_S) / mhz) / {32'h0, PWM_DIV};
      pwm_period = (cyc[31:0] == 32'h0) ? 32'h1 : cyc[31:0];
    end
  endfunction

  // Mapped register check
  function mapped;
    input [9:0] idx;
    begin
      mapped = (idx == `IDX_FIRST_CONFIG) || (idx == `IDX_SECOND_STATUS) ||
               (idx == `IDX_FRACTIONAL_TEMP) || (idx == `IDX_FAN_ONE_CHAR) ||
               (idx == `IDX_FAN_TWO_CHAR) || (idx == `IDX_FAN_SPEED) ||
               (idx == `IDX_FAN_FILTER);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg [7:0] fan_one_char; // Spin-up, frequency, speed range for fan one
  reg [7:0] fan_two_char; // Same for fan two
  reg [7:0] fan_speed; // Two speed nibbles
  reg [7:0] fan_filter; // Spin disable, ramp, sample rate, filters
  reg [7:0] status_flags; // Second status register
  reg [7:0] frac_bits; // Fraction bits, tracks inputs
  reg alarm_quiet; // Alarm flag held off after a read
  reg diode_tested; // Power-up diode check done
  reg therm_meta; // Thermal pin first stage
  reg therm_sync; // Thermal pin second stage
  reg aw_held; // Write address captured
  reg w_held; // Write data captured
  reg [9:0] aw_idx; // Captured write index
  reg [31:0] w_data; // Captured write data
  reg w_lane0; // Low byte lane enabled
  reg [31:0] ms_cnt; // Millisecond prescaler
  reg ms_tick; // One pulse per millisecond
  reg [31:0] adc_cnt; // Converter sample counter
  reg [3:0] prev_target [0:1]; // Last requested duty per fan
  reg [12:0] spin_left [0:1]; // Spin-up ms remaining per fan
  reg [31:0] pwm_cnt [0:1]; // PWM period counter per fan
  // Combinational terms: flag events, read mux, duty compare, bus decode
  reg [7:0] next_status;
  reg [7:0] status_set;
  reg [31:0] read_word;
  reg [3:0] target [0:1];
  reg [2:0] spin_code [0:1];
  reg [31:0] period [0:1];
  reg [3:0] applied [0:1];
  reg [39:0] lhs [0:1];
  reg [39:0] rhs [0:1];
  wire [9:0] ar_idx;
  wire rd_take;
  wire rd_status;
  wire wr_do;
  wire [31:0] adc_period;
  integer i;
  localparam [7:0] RST_CONFIG = `RST_FIRST_CONFIG; // Reset of first config

  assign ar_idx = araddr[11:2];
  assign rd_take = arvalid && arready;
  assign rd_status = rd_take && (ar_idx == `IDX_SECOND_STATUS);
  assign wr_do = aw_held && w_held && !bvalid;
  assign adc_period = ADC_BASE_CYCLES >> fan_filter[`FLD_ADC_RATE]; // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // Status flag events; a set in the clearing cycle wins

  always @*
  begin
    status_set = 8'h00;
    status_set[`BIT_ALARM_SPEED] = monitor_cycle && fan_two_alarm_speed && !alarm_quiet; // RULE1
    status_set[`BIT_FAN_FAULT] = fan_two_stalled; // RULE2
    status_set[`BIT_REMOTE_HIGH] = monitor_cycle && remote_two_above_high; // RULE3
    status_set[`BIT_REMOTE_LOW] = monitor_cycle && remote_two_below_low; // RULE3
    status_set[`BIT_REMOTE_THERM] = remote_two_over_therm; // RULE4
    status_set[`BIT_LOCAL_THERM] = local_over_therm; // RULE6
    status_set[`BIT_THERM_PIN] = !therm_sync; // RULE7
    next_status = status_flags;
    // Read clears all flags except the diode error
    if (rd_status)
    begin
      next_status = 8'h00;
      next_status[`BIT_DIODE_ERROR] = status_flags[`BIT_DIODE_ERROR]; // RULE5
    end
    next_status = next_status | status_set; // RULE4 RULE6 RULE7
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always @*
  begin
    read_word = 32'h0;
    case (ar_idx)
      `IDX_FIRST_CONFIG: read_word[`BIT_CONTROL_SOURCE] = control_source_select;
      `IDX_SECOND_STATUS: read_word[7:0] = status_flags;
      `IDX_FRACTIONAL_TEMP: read_word[7:0] = frac_bits; // RULE8
      `IDX_FAN_ONE_CHAR: read_word[7:0] = fan_one_char;
      `IDX_FAN_TWO_CHAR: read_word[7:0] = fan_two_char;
      `IDX_FAN_SPEED: read_word[7:0] = fan_speed;
      `IDX_FAN_FILTER: read_word[7:0] = fan_filter; // RULE17
      default: read_word = 32'h0; // Unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-fan duty selection and PWM compare

  always @*
  begin
    spin_code[0] = fan_one_char[`FLD_SPIN_UP];
    spin_code[1] = fan_two_char[`FLD_SPIN_UP];
    period[0] = pwm_period(fan_one_char[`FLD_PWM_FREQ]); // RULE10
    period[1] = pwm_period(fan_two_char[`FLD_PWM_FREQ]); // RULE10
    // Automatic mode treats the nibble as a floor
    if (control_source_select) // RULE16
    begin
      target[0] = (auto_demand_one > fan_speed[`FLD_NIBBLE_ONE]) ?
                  auto_demand_one : fan_speed[`FLD_NIBBLE_ONE]; // RULE11
      target[1] = (auto_demand_two > fan_speed[`FLD_NIBBLE_TWO]) ?
                  auto_demand_two : fan_speed[`FLD_NIBBLE_TWO]; // RULE11
    end
    else
    begin
      target[0] = fan_speed[`FLD_NIBBLE_ONE]; // RULE11
      target[1] = fan_speed[`FLD_NIBBLE_TWO]; // RULE11
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      applied[i] = (spin_left[i] != 13'h0) ? `DUTY_FULL : target[i]; // RULE18
      // Compare cnt/period against duty/15 without a divider
      lhs[i] = {8'h0, pwm_cnt[i]} * {32'h0, `DUTY_STEPS};
      rhs[i] = {8'h0, period[i]} * {36'h0, applied[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register writes

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      control_source_select <= RST_CONFIG[`BIT_CONTROL_SOURCE]; // RULE16
      fan_one_char <= `RST_FAN_CHAR; // RULE9 RULE10
      fan_two_char <= `RST_FAN_CHAR;
      fan_speed <= `RST_FAN_SPEED; // RULE11
      fan_filter <= `RST_FAN_FILTER; // RULE17
    end
    else
    begin
      // Address and data are taken in either order
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        aw_idx <= awaddr[11:2];
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_lane0 <= wstrb[0];
      end
      // Commit once both halves are held
      if (wr_do)
      begin
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        if (w_lane0)
        begin
          case (aw_idx)
            `IDX_FIRST_CONFIG: control_source_select <= w_data[`BIT_CONTROL_SOURCE];
            `IDX_FAN_ONE_CHAR: fan_one_char <= w_data[7:0]; // RULE9
            `IDX_FAN_TWO_CHAR: fan_two_char <= w_data[7:0]; // RULE9
            `IDX_FAN_SPEED: fan_speed <= w_data[7:0]; // RULE11
            `IDX_FAN_FILTER: fan_filter <= w_data[7:0]; // RULE17
            default: bresp <= `RESP_OKAY; // Read-only targets ignore writes
          endcase
        end
        // Unmapped addresses answer with an error
        if (!mapped(aw_idx))
        begin
          bresp <= `RESP_SLVERR;
        end
      end
      // Release both channels when the response is taken
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // One read at a time; data follows one cycle after the address
      if (rd_take)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, diode check and thermal pin synchroniser

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_flags <= `RST_SECOND_STATUS;
      alarm_quiet <= 1'b0;
      diode_tested <= 1'b0;
      therm_meta <= 1'b1;
      therm_sync <= 1'b1;
      frac_bits <= `RST_FRACTIONAL_TEMP;
    end
    else
    begin
      therm_meta <= therm_pin_n;
      therm_sync <= therm_meta; // RULE7
      frac_bits <= {frac_local, frac_remote_two, frac_remote_one}; // RULE8
      status_flags <= next_status;
      // Diode test happens only in the first cycle after reset
      if (!diode_tested)
      begin
        diode_tested <= 1'b1;
        status_flags[`BIT_DIODE_ERROR] <= remote_two_diode_fault; // RULE5
      end
      // Hold off reassertion until the alarm condition goes away
      if (!fan_two_alarm_speed)
      begin
        alarm_quiet <= 1'b0;
      end
      else if (rd_status && !status_set[`BIT_ALARM_SPEED])
      begin
        alarm_quiet <= 1'b1; // RULE1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and converter sample tick

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b0;
      adc_cnt <= 32'h0;
      adc_sample_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (ms_cnt >= MS_CYCLES - 32'h1);
      ms_cnt <= (ms_cnt >= MS_CYCLES - 32'h1) ? 32'h0 : ms_cnt + 32'h1;
      // Period halves per code step, so the rate doubles
      adc_sample_tick <= (adc_cnt >= adc_period - 32'h1); // RULE14
      adc_cnt <= (adc_cnt >= adc_period - 32'h1) ? 32'h0 : adc_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spin-up timers, PWM counters and fan outputs

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        prev_target[i] <= 4'h0;
        spin_left[i] <= 13'h0;
        pwm_cnt[i] <= 32'h0;
      end
      fan_duty_one <= 4'h0;
      fan_duty_two <= 4'h0;
      pwm_fan_one <= 1'b0;
      pwm_fan_two <= 1'b0;
      fan_filter_en_one <= 1'b0;
      fan_filter_en_two <= 1'b0;
      ramp_factor <= 4'h1;
    end
    else
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        prev_target[i] <= target[i];
        if (fan_filter[`BIT_SPIN_DISABLE])
        begin
          spin_left[i] <= 13'h0; // RULE12
        end
        else if (prev_target[i] == 4'h0 && target[i] != 4'h0)
        begin
          spin_left[i] <= spin_ms(spin_code[i]); // RULE9 RULE18
        end
        else if (ms_tick && spin_left[i] != 13'h0)
        begin
          spin_left[i] <= spin_left[i] - 13'h1;
        end
        // Period change may leave the counter past the end; wrap at once
        pwm_cnt[i] <= (pwm_cnt[i] >= period[i] - 32'h1) ? 32'h0 : pwm_cnt[i] + 32'h1;
      end
      fan_duty_one <= applied[0]; // RULE18
      fan_duty_two <= applied[1];
      pwm_fan_one <= lhs[0] < rhs[0]; // RULE10
      pwm_fan_two <= lhs[1] < rhs[1];
      fan_filter_en_one <= fan_filter[`BIT_FILTER_ONE]; // RULE15
      fan_filter_en_two <= fan_filter[`BIT_FILTER_TWO]; // RULE15
      ramp_factor <= 4'h1 << fan_filter[`FLD_RAMP]; // RULE13
    end
  end

endmodule // fan_monitor_status_config

`default_nettype wire

// ==== fan_monitor_status_config_map.vh ====
// Constants for the fan monitor status and fan configuration register bank.
// Assumes the includer works at a 50 MHz clock and a 32-bit AXI4-Lite data path.
`ifndef FAN_MONITOR_STATUS_CONFIG_MAP_VH
`define FAN_MONITOR_STATUS_CONFIG_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is four times the index)
`define IDX_FIRST_CONFIG 10'h000
`define IDX_SECOND_STATUS 10'h003
`define IDX_FRACTIONAL_TEMP 10'h006
`define IDX_FAN_ONE_CHAR 10'h020
`define IDX_FAN_TWO_CHAR 10'h021
`define IDX_FAN_SPEED 10'h022
`define IDX_FAN_FILTER 10'h023

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_FIRST_CONFIG 8'h80
`define RST_SECOND_STATUS 8'h00
`define RST_FRACTIONAL_TEMP 8'h00
`define RST_FAN_CHAR 8'h1D
`define RST_FAN_SPEED 8'h55
`define RST_FAN_FILTER 8'h50

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define BIT_CONTROL_SOURCE 7
`define BIT_ALARM_SPEED 0
`define BIT_FAN_FAULT 1
`define BIT_REMOTE_HIGH 2
`define BIT_REMOTE_LOW 3
`define BIT_REMOTE_THERM 4
`define BIT_DIODE_ERROR 5
`define BIT_LOCAL_THERM 6
`define BIT_THERM_PIN 7
`define FLD_SPIN_UP 2:0
`define FLD_PWM_FREQ 5:3
`define FLD_NIBBLE_ONE 3:0
`define FLD_NIBBLE_TWO 7:4
`define BIT_SPIN_DISABLE 7
`define FLD_RAMP 6:5
`define FLD_ADC_RATE 4:2
`define BIT_FILTER_TWO 1
`define BIT_FILTER_ONE 0

////////////////////////////////////////////////////////////////////////////////
// Timing: clock rate, spin-up times in ms, PWM rates in mHz
`define CLK_HZ 64'd50000000
`define MS_PER_S 64'd1000
`define SPIN_MS_0 13'd200
`define SPIN_MS_1 13'd400
`define SPIN_MS_2 13'd600
`define SPIN_MS_3 13'd800
`define SPIN_MS_4 13'd1000
`define SPIN_MS_5 13'd2000
`define SPIN_MS_6 13'd4000
`define SPIN_MS_7 13'd8000
`define PWM_MHZ_0 64'd11700
`define PWM_MHZ_1 64'd15600
`define PWM_MHZ_2 64'd23400
`define PWM_MHZ_3 64'd31250
`define PWM_MHZ_4 64'd37500
`define PWM_MHZ_5 64'd46900
`define PWM_MHZ_6 64'd62500
`define PWM_MHZ_7 64'd93500
`define DUTY_FULL 4'hF
`define DUTY_STEPS 8'h0F

////////////////////////////////////////////////////////////////////////////////
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== fan_monitor_status_config_assertions.sv ====
// Checker of bus answers and fan outputs of the register bank.
// Assumes it is bound onto the bank's top module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fan_bank_checker (
  input wire aclk, // Clock
  input wire aresetn, // Reset, active low
  input wire awvalid, // AW valid
  input wire awready, // AW ready
  input wire wvalid, // W valid
  input wire wready, // W ready
  input wire bvalid, // B valid
  input wire arvalid, // AR valid
  input wire arready, // AR ready
  input wire [31:0] rdata, // Read data
  input wire [1:0] rresp, // Read response
  input wire rvalid, // R valid
  input wire control_source_select, // High for automatic
  input wire [3:0] fan_duty_one, // Duty, fan one
  input wire pwm_fan_one, // PWM, fan one
  input wire [3:0] ramp_factor, // Ramp factor
  input wire adc_sample_tick // Sample pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers; a slow answer would stall the whole bank
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer missing");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_slverr_data: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("error read carries data");
  ////////////////////////////////////////////////////////////////////////////////
  // Fan side outputs
  a_ramp_power: assert property (ramp_factor inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("ramp factor not a power of two");
  a_tick_single: assert property (adc_sample_tick |=> !adc_sample_tick)
    else $error("sample tick too long");
  a_full_drive: assert property (fan_duty_one == 4'hF [*3] |-> pwm_fan_one)
    else $error("full duty not driven");
  a_zero_drive: assert property (fan_duty_one == 4'h0 [*3] |-> !pwm_fan_one)
    else $error("zero duty drives fan");
  a_auto_reset: assert property ($rose(aresetn) |-> control_source_select)
    else $error("control source not automatic");
  c_write: cover property (bvalid);
  c_slverr: cover property (rvalid && rresp == 2'h2);
  c_spin_end: cover property (fan_duty_one == 4'hF ##1 fan_duty_one != 4'hF);
endmodule // fan_bank_checker
bind fan_monitor_status_config fan_bank_checker fan_bank_checker_inst (.*);
`default_nettype wire

// ==== fan_model.sv ====
// Behavioural cooling fan on a PWM drive, reporting a stall.
// Assumes PWM from the bank on aclk; jam stands for a seized rotor.
`timescale 1ns/1ps
`default_nettype none
module fan_model #(
  parameter int STALL_CYCLES = 200 // Undriven cycles before the rotor stops
) (
  input wire logic aclk, // Clock
  input wire logic pwm, // Drive from the bank
  input wire logic jam, // Seized rotor on command
  output logic stalled // Stuck or under speed
);
  int low_cnt = 0; // Cycles without drive
  // An undriven fan coasts down and is then seen as stalled
  always @(posedge aclk)
    low_cnt <= pwm ? 0 : (low_cnt < STALL_CYCLES ? low_cnt + 1 : low_cnt);
  assign stalled = jam || (low_cnt >= STALL_CYCLES);
endmodule // fan_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the fan monitor status and configuration bank.
// Assumes the shortened counts given to the bank below.
`timescale 1ns/1ps
`default_nettype none
`include "fan_monitor_status_config_map.vh"
module tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0; // Bus strobes
  logic bready = 0, rready = 0; // Answer readies
  logic [11:0] awaddr = 12'h0, araddr = 12'h0; // Addresses
  logic [31:0] wdata = 32'h0, r; // Write data, random word
  wire awready, wready, bvalid, arready, rvalid, stalled, css, pwm1, pwm2, fe1, fe2, tick;
  wire [1:0] bresp, rresp; // Responses
  wire [31:0] rdata; // Read data
  wire [3:0] duty1, duty2, ramp; // Fan outputs
  logic mon = 0, alarm = 0, jam = 0, hi = 0, lo = 0, r2th = 0, lth = 0, diode = 1, pin_n = 1;
  logic [7:0] frac = 8'h0, v; // Fraction inputs, filter value
  logic [3:0] dem = 4'h0; // Loop demand
  logic [31:0] seed = 32'h24765636; // Xorshift state
  logic [33:0] expq [$]; // Expected {resp, data}
  int err_total = 0, num_checks = 0, cyc = 0, t0; // Counters
  localparam logic [11:0] ST = {`IDX_SECOND_STATUS, 2'h0}, FL = {`IDX_FAN_FILTER, 2'h0};
  localparam logic [11:0] SP = {`IDX_FAN_SPEED, 2'h0}, C0 = {`IDX_FIRST_CONFIG, 2'h0};
  fan_monitor_status_config #(.MS_CYCLES(32'hA), .ADC_BASE_CYCLES(32'h100),
    .PWM_DIV(32'h4E20)) fan_monitor_status_config_inst (.aclk, .aresetn, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .monitor_cycle(mon),
    .fan_two_alarm_speed(alarm), .fan_two_stalled(stalled), .remote_two_above_high(hi),
    .remote_two_below_low(lo), .remote_two_over_therm(r2th), .remote_two_diode_fault(diode),
    .local_over_therm(lth), .therm_pin_n(pin_n), .frac_remote_one(frac[2:0]),
    .frac_remote_two(frac[5:3]), .frac_local(frac[7:6]), .auto_demand_one(dem),
    .auto_demand_two(dem), .control_source_select(css), .fan_duty_one(duty1),
    .fan_duty_two(duty2), .pwm_fan_one(pwm1), .pwm_fan_two(pwm2), .fan_filter_en_one(fe1),
    .fan_filter_en_two(fe2), .ramp_factor(ramp), .adc_sample_tick(tick));
  fan_model fan_model_inst (.aclk, .pwm(pwm2), .jam, .stalled);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and shared tasks
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic ok, input string what);
    num_checks++;
    if (!ok)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write holds each channel until its own ready, then waits for the answer
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    {aw_d, w_d} = 2'h0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      aw_d = aw_d | awready;
      w_d = w_d | wready;
    end
    while (!(aw_d && w_d));
    do @(posedge aclk); while (!bvalid);
    chk(bresp === `RESP_OKAY, "write response");
    bready <= 0;
    @(posedge aclk);
  endtask
  // Read notes its expectation; a watcher compares it
  task rd(input logic [11:0] a, input logic [33:0] e);
    expq.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask
  always @(posedge aclk)
    if (rvalid && expq.size() > 0)
      chk({rresp, rdata} === expq.pop_front(), "read data");
  task pulse();
    mon <= 1;
    @(posedge aclk);
    mon <= 0;
    @(posedge aclk);
  endtask
  task wait_tick();
    do @(posedge aclk); while (!tick);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    diode <= 0; // Fault gone after the power-up test
    rd(ST, 34'h20);
    rd(C0, 34'h80);
    rd({`IDX_FAN_ONE_CHAR, 2'h0}, 34'h1D);
    rd({`IDX_FAN_TWO_CHAR, 2'h0}, 34'h1D);
    rd(SP, 34'h55);
    rd(FL, 34'h50);
    rd(12'hFFC, 34'h200000000);
    chk(ramp === 4'h4 && {fe2, fe1} === 2'h0 && css === 1'h1, "reset outputs");
    $display("test reset values done");
    alarm <= 1;
    pulse();
    rd(ST, 34'h21);
    pulse();
    rd(ST, 34'h20);
    {alarm, hi, lo} <= 3'h3;
    pulse();
    rd(ST, 34'h2C);
    pulse();
    rd(ST, 34'h2C);
    {hi, lo, r2th, lth, pin_n} <= 5'h6;
    repeat (5) @(posedge aclk);
    {r2th, lth, pin_n, jam} <= 4'h3;
    repeat (5) @(posedge aclk);
    jam <= 0;
    pulse();
    rd(ST, 34'hF2);
    wr(ST, 32'hFF);
    rd(ST, 34'h20);
    $display("test status flags done");
    repeat (4)
    begin
      r = xs();
      frac <= r[7:0];
      repeat (3) @(posedge aclk);
      rd({`IDX_FRACTIONAL_TEMP, 2'h0}, {26'h0, r[7:0]});
    end
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      v = {1'h0, i[1:0], i[2:0], r[1:0]};
      wr(FL, {24'h0, v});
      rd(FL, {26'h0, v});
      chk(ramp === (4'h1 << i[1:0]) && {fe2, fe1} === v[1:0], "ramp or filter");
      repeat (2) wait_tick();
      t0 = cyc;
      wait_tick();
      chk(cyc - t0 == (256 >> i), "sample interval");
    end
    wr(FL, 32'h50);
    $display("test filter register done");
    while (duty1 === 4'hF) @(posedge aclk);
    chk(cyc > 20000 && cyc < 20050, "boot spin time");
    @(posedge aclk);
    chk(duty1 === 4'h5, "reset speed");
    wr(C0, 32'h0);
    wr({`IDX_FAN_ONE_CHAR, 2'h0}, 32'h18);
    wr(SP, 32'h50);
    repeat (3) @(posedge aclk);
    chk(css === 1'h0 && duty1 === 4'h0, "software stop");
    wr(SP, 32'h53);
    t0 = cyc;
    repeat (3) @(posedge aclk);
    chk(duty1 === 4'hF, "spin full duty");
    while (duty1 === 4'hF) @(posedge aclk);
    chk(cyc - t0 > 1995 && cyc - t0 < 2010 && duty1 === 4'h3, "spin time");
    wr(FL, 32'hD0);
    wr(SP, 32'h50);
    wr(SP, 32'h57);
    repeat (3) @(posedge aclk);
    chk(duty1 === 4'h7, "spin skipped");
    wr(C0, 32'h80);
    dem <= 4'h9;
    repeat (3) @(posedge aclk);
    chk(duty1 === 4'h9 && duty2 === 4'h9, "automatic demand");
    $display("test fan drive done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
